// >>> rtl/csrf_pkg.sv
// Constants and types shared by the clock select and reset filter block.
package csrf_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] CSRF_CTRL_OFS = 12'h000;
   localparam logic [11:0] CSRF_STATUS_OFS = 12'h004;
   localparam logic [11:0] CSRF_RSTCNT_OFS = 12'h008;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_CLKOUT_EN_BIT = 0;
   localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0001;
   localparam int STAT_SRC_EXT_BIT = 0;
   localparam int STAT_TEST_BIT = 1;
   localparam int STAT_SYSRST_BIT = 2;
   localparam int STAT_RST_SEEN_BIT = 3;
   localparam int STAT_MF_LSB = 8;
   localparam int MF_W = 7;
   localparam int RSTCNT_W = 8;
   localparam logic [31:0] APB_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Clock multiplication factors, in tenths
   // ----------------------------------------------------------------
   localparam logic [MF_W-1:0] PLL_MF_NORM_X10 = 7'h32;
   localparam logic [MF_W-1:0] PLL_MF_TEST_X10 = 7'h42;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int RST_MIN_LOW_CYCLES = 64;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_COUNT,
      ST_RESET
   } csrf_filt_state_t;

endpackage

// >>> rtl/csrf_rst_if.sv
// Carrier between the block's control logic and its reset filter.
`timescale 1ns/100ps
interface csrf_rst_if #(parameter int CNT_W = 7) ();
   logic ce;
   logic rst_pin_n;
   logic [CNT_W-1:0] low_cnt;
   logic rst_active;

   modport filt (input ce, input rst_pin_n, output low_cnt, output rst_active);
   modport ctl (output ce, output rst_pin_n, input low_cnt, input rst_active);
endinterface

// >>> rtl/csrf_rst_filter.sv
// Digital filter that accepts a reset only after a long enough low level.
`timescale 1ns/100ps
module csrf_rst_filter import csrf_pkg::*; #(
   parameter int RST_LOW_CYCLES = RST_MIN_LOW_CYCLES,
   parameter int CNT_W = 7
) (
   input wire logic pclk,           // Master clock.
   input wire logic presetn,        // Asynchronous reset, active low.
   csrf_rst_if.filt rif             // Pin in, filtered reset out.
);

   csrf_filt_state_t state_r;
   csrf_filt_state_t state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic rst_active_r;

   localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(RST_LOW_CYCLES - 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(RST_LOW_CYCLES);
   localparam logic [CNT_W-1:0] ONE_CNT = CNT_W'(1);

   // ----------------------------------------------------------------
   // Low level counting
   // ----------------------------------------------------------------
   // A single high sample restarts the count, so glitches never add up.
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         ST_RUN: begin
            if (!rif.rst_pin_n) begin
               state_nxt = ST_COUNT;
               cnt_nxt = ONE_CNT;
            end
         end
         ST_COUNT: begin
            if (rif.rst_pin_n) begin
               state_nxt = ST_RUN;
               cnt_nxt = '0;
            end else if (cnt_r == LAST_CNT) begin
               state_nxt = ST_RESET;
               cnt_nxt = FULL_CNT;
            end else begin
               cnt_nxt = cnt_r + ONE_CNT;
            end
         end
         ST_RESET: begin
            if (rif.rst_pin_n) begin
               state_nxt = ST_RUN;
               cnt_nxt = '0;
            end
         end
         default: begin
            state_nxt = ST_RUN;
            cnt_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_RUN;
         cnt_r <= '0;
         rst_active_r <= 1'b0;
      end else if (rif.ce) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         rst_active_r <= (state_nxt == ST_RESET);
      end
   end

   assign rif.low_cnt = cnt_r;
   assign rif.rst_active = rst_active_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_RST_MIN_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(rst_active_r) |-> ($past(cnt_r) == LAST_CNT) && !$past(rif.rst_pin_n))
      else $error("Reset accepted before the minimum low time.");

   AST_RST_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
      (rif.ce && rif.rst_pin_n) |=> !rst_active_r && (cnt_r == '0))
      else $error("Filtered reset held after the pin went high.");

endmodule

// >>> rtl/csrf_top.sv
// Clock source select, multiplier strap, clock output and reset filter.
//
// Contract
// - Low clock_source_select picks the PLL output as system clock, high picks ext_clock_in.
// - global_reset_n must stay low 64 master cycles and only then is a system reset accepted.
// - test_mode_pin low means normal operation, high means chip test mode.
// - With test_mode_pin low the PLL multiplies its input by five.
// - With test_mode_pin high the PLL multiplies its input by 6.6.
// - sys_clock_out follows the internal system clock in phase, some delay later.
// - The same clock output also serves as sdram_clock_out.
// - clock_out_enable turns the system clock output on and off.
// - The JTAG reset input clears the JTAG logic at once, without the clock.
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module csrf_top import csrf_pkg::*; #(
   parameter int ADDR_W = 12,
   parameter int RST_LOW_CYCLES = RST_MIN_LOW_CYCLES
) (
   input wire logic pclk,                  // Master clock, 10 MHz.
   input wire logic presetn,               // Asynchronous reset, active low.
   input wire logic ce,                    // Clock enable; low freezes all state.
   input wire logic psel,                  // APB select.
   input wire logic penable,               // APB access phase.
   input wire logic pwrite,                // APB write when high.
   input wire logic [ADDR_W-1:0] paddr,    // APB byte address.
   input wire logic [31:0] pwdata,         // APB write data.
   output logic [31:0] prdata,             // APB read data.
   output logic pready,                    // APB ready.
   output logic pslverr,                   // APB error on unmapped address.
   input wire logic clock_source_select,   // Strap: 0 PLL, 1 external clock.
   input wire logic test_mode_pin,         // Strap: 1 chip test mode.
   input wire logic clock_out_enable,      // Pin enable for the clock output.
   input wire logic global_reset_n,        // Board reset, active low.
   input wire logic jtag_reset_n,          // JTAG reset, active low.
   output logic sys_clk_sel_ext,           // Clock mux select, 1 picks external clock.
   output logic [MF_W-1:0] pll_mult_x10,   // PLL factor in tenths.
   output logic test_mode_active,          // Chip test mode.
   output logic sys_clock_out,             // Image of the internal system clock.
   output logic sdram_clock_out,           // Clock for external SDRAM.
   output logic sys_reset_n,               // Filtered internal reset, active low.
   output logic jtag_logic_rst_n           // Reset for the JTAG logic, active low.
);

   localparam int CNT_W = $clog2(RST_LOW_CYCLES + 1);
   localparam logic [RSTCNT_W-1:0] RSTCNT_ONE = RSTCNT_W'(1);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [31:0] ctrl_r;
   logic [31:0] ctrl_nxt;
   logic rst_seen_r;
   logic rst_seen_nxt;
   logic [RSTCNT_W-1:0] rst_cnt_r;
   logic [RSTCNT_W-1:0] rst_cnt_nxt;
   logic filt_d_r;
   logic clk_phase_r;
   logic sel_ext_r;
   logic [MF_W-1:0] mf_r;
   logic [MF_W-1:0] mf_nxt;
   logic test_r;
   logic clk_out_r;
   logic sdram_clk_r;
   logic sys_rst_n_r;
   logic jtag_rst_n_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;

   csrf_rst_if #(.CNT_W(CNT_W)) rif ();

   // ----------------------------------------------------------------
   // Reset filter
   // ----------------------------------------------------------------
   assign rif.ce = ce;
   assign rif.rst_pin_n = global_reset_n;

   csrf_rst_filter #(
      .RST_LOW_CYCLES(RST_LOW_CYCLES),
      .CNT_W(CNT_W)
   ) u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .rif(rif)
   );

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire apb_access = psel && penable;
   wire apb_done = apb_access && pready_r;
   wire hit_ctrl = (paddr == ADDR_W'(CSRF_CTRL_OFS));
   wire hit_status = (paddr == ADDR_W'(CSRF_STATUS_OFS));
   wire hit_rstcnt = (paddr == ADDR_W'(CSRF_RSTCNT_OFS));
   wire hit_any = hit_ctrl || hit_status || hit_rstcnt;
   wire wr_ctrl = apb_done && pwrite && hit_ctrl;
   wire wr_status = apb_done && pwrite && hit_status;
   wire clr_seen = wr_status && pwdata[STAT_RST_SEEN_BIT];

   wire [31:0] status_word = {16'h0000, 1'b0, mf_r, 4'h0, rst_seen_r, !sys_rst_n_r, test_r, sel_ext_r};
   wire [31:0] rstcnt_word = {{(32 - RSTCNT_W){1'b0}}, rst_cnt_r};
   wire [31:0] rd_word = hit_ctrl ? ctrl_r :
                         hit_status ? status_word :
                         hit_rstcnt ? rstcnt_word : APB_ZERO;

   // ----------------------------------------------------------------
   // Strap and clock logic
   // ----------------------------------------------------------------
   wire filt_rise = rif.rst_active && !filt_d_r;
   wire clk_out_gate = clock_out_enable && ctrl_r[CTRL_CLKOUT_EN_BIT];

   assign mf_nxt = test_mode_pin ? PLL_MF_TEST_X10 : PLL_MF_NORM_X10;
   assign ctrl_nxt = wr_ctrl ? pwdata : ctrl_r;
   // A reset caught in the same cycle as the clear keeps the flag set.
   assign rst_seen_nxt = filt_rise || (rst_seen_r && !clr_seen);
   assign rst_cnt_nxt = filt_rise ? rst_cnt_r + RSTCNT_ONE : rst_cnt_r;

   // ----------------------------------------------------------------
   // APB slave: one wait state, answer from registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         prdata_r <= APB_ZERO;
         pslverr_r <= 1'b0;
      end else if (ce) begin
         pready_r <= apb_access && !pready_r;
         prdata_r <= (apb_access && !pready_r && !pwrite) ? rd_word : APB_ZERO;
         pslverr_r <= apb_access && !pready_r && !hit_any;
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RESET_VAL;
         rst_seen_r <= 1'b0;
         rst_cnt_r <= '0;
         filt_d_r <= 1'b0;
      end else if (ce) begin
         ctrl_r <= ctrl_nxt;
         rst_seen_r <= rst_seen_nxt;
         rst_cnt_r <= rst_cnt_nxt;
         filt_d_r <= rif.rst_active;
      end
   end

   // ----------------------------------------------------------------
   // Clock selection, multiplier and test mode
   // ----------------------------------------------------------------
   // The straps are sampled every cycle; the clock mux outside is expected
   // to switch glitch free, so a strap change is only passed on, not filtered.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_ext_r <= 1'b0;
         mf_r <= PLL_MF_NORM_X10;
         test_r <= 1'b0;
      end else if (ce) begin
         sel_ext_r <= clock_source_select;
         mf_r <= mf_nxt;
         test_r <= test_mode_pin;
      end
   end

   // ----------------------------------------------------------------
   // Clock output
   // ----------------------------------------------------------------
   // The internal clock image runs at half the master rate; the output is a
   // registered copy, so it lags the internal phase by one master cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_phase_r <= 1'b0;
         clk_out_r <= 1'b0;
         sdram_clk_r <= 1'b0;
      end else if (ce) begin
         clk_phase_r <= !clk_phase_r;
         clk_out_r <= clk_out_gate && clk_phase_r;
         sdram_clk_r <= clk_out_gate && clk_phase_r;
      end
   end

   // ----------------------------------------------------------------
   // Resets
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_rst_n_r <= 1'b0;
      end else if (ce) begin
         sys_rst_n_r <= !rif.rst_active;
      end
   end

   // Only the clear is asynchronous; release waits for a clock edge.
   always_ff @(posedge pclk or negedge jtag_reset_n) begin
      if (!jtag_reset_n) begin
         jtag_rst_n_r <= 1'b0;
      end else if (ce) begin
         jtag_rst_n_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign sys_clk_sel_ext = sel_ext_r;
   assign pll_mult_x10 = mf_r;
   assign test_mode_active = test_r;
   assign sys_clock_out = clk_out_r;
   assign sdram_clock_out = sdram_clk_r;
   assign sys_reset_n = sys_rst_n_r;
   assign jtag_logic_rst_n = jtag_rst_n_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_SRC_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
      ce |=> (sys_clk_sel_ext == $past(clock_source_select)))
      else $error("Clock source select does not follow the strap.");

   AST_TEST_MODE: assert property (@(posedge pclk) disable iff (!presetn)
      ce |=> (test_mode_active == $past(test_mode_pin)))
      else $error("Test mode does not follow the strap.");

   AST_MF_NORMAL: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && !test_mode_pin) |=> (pll_mult_x10 == PLL_MF_NORM_X10) && !test_mode_active)
      else $error("Normal mode multiplier is not five.");

   AST_MF_TEST: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && test_mode_pin) |=> (pll_mult_x10 == PLL_MF_TEST_X10) && test_mode_active)
      else $error("Test mode multiplier is not 6.6.");

   AST_CLKOUT_PHASE: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && clk_out_gate && clk_phase_r) |=> sys_clock_out && !clk_phase_r)
      else $error("Clock output is not in phase with the internal clock.");

   AST_SDRAM_SAME: assert property (@(posedge pclk) disable iff (!presetn)
      sdram_clock_out == sys_clock_out)
      else $error("SDRAM clock differs from the system clock output.");

   AST_CLKOUT_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && !clock_out_enable) |=> !sys_clock_out [*1] ##0 !sdram_clock_out)
      else $error("Clock output runs while disabled.");

   AST_JTAG_ASYNC: assert property (@(posedge pclk)
      !jtag_reset_n |-> !jtag_logic_rst_n)
      else $error("JTAG logic not held in reset.");

   AST_SYNC_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && rif.rst_active) |=> !sys_reset_n ##1 (!$past(ce) || sys_reset_n == !$past(rif.rst_active)))
      else $error("Internal reset not tied to the filtered reset.");

   // The low count must never run past the accept point, or a reset could be missed.
   AST_FILT_CNT: assert property (@(posedge pclk) disable iff (!presetn)
      rif.low_cnt <= CNT_W'(RST_LOW_CYCLES))
      else $error("Reset filter count ran past its limit.");

   AST_APB_ONE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && apb_access && !pready_r) |=> pready_r ##1 (!pready_r || !$past(ce)))
      else $error("APB answer does not come after one wait state.");

endmodule

// >>> tb/csrf_board_model.sv
// Board side model: clock straps, clock output pin enable and reset circuits.
`timescale 1ns/100ps
module csrf_board_model import csrf_pkg::*; (
   input wire logic pclk,             // Master clock.
   output logic clock_source_select,  // Strap: 0 PLL, 1 external clock.
   output logic test_mode_pin,        // Strap: 1 chip test mode.
   output logic clock_out_enable,     // Clock output pin enable.
   output logic global_reset_n,       // Board reset, active low.
   output logic jtag_reset_n          // JTAG reset, active low.
);
   initial begin
      clock_source_select = 1'b0;
      test_mode_pin = 1'b0;
      clock_out_enable = 1'b1;
      global_reset_n = 1'b1;
      jtag_reset_n = 1'b1;
   end

   task automatic set_pins(input logic sel, input logic tm, input logic oe);
      @(posedge pclk);
      clock_source_select <= sel;
      test_mode_pin <= tm;
      clock_out_enable <= oe;
   endtask

   // A real reset circuit holds the line for the full minimum; shorter pulses are only made on request.
   task automatic hold_reset(input int n = RST_MIN_LOW_CYCLES);
      @(posedge pclk);
      global_reset_n <= 1'b0;
      repeat (n) @(posedge pclk);
      global_reset_n <= 1'b1;
   endtask

   task automatic set_jtag(input logic lvl);
      @(posedge pclk);
      jtag_reset_n <= lvl;
   endtask
endmodule

// >>> tb/tb_clock_select_reset_filter.sv
// Self-checking bench for the clock select and reset filter block.
`timescale 1ns/100ps
module tb_clock_select_reset_filter import csrf_pkg::*; ();
   logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, sel_ext, test_act, sclk_o, sdram_clock_out_o, srst_n, jrst_n;
   logic [MF_W-1:0] mult;
   logic cs, tm, coe, grn, jrn;
   int num_errors = 0, n_compared = 0;

   always #50 pclk = ~pclk;

   csrf_board_model csrf_board_model_i (.pclk(pclk), .clock_source_select(cs), .test_mode_pin(tm),
      .clock_out_enable(coe), .global_reset_n(grn), .jtag_reset_n(jrn));

   csrf_top csrf_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clock_source_select(cs), .test_mode_pin(tm), .clock_out_enable(coe),
      .global_reset_n(grn), .jtag_reset_n(jrn), .sys_clk_sel_ext(sel_ext), .pll_mult_x10(mult),
      .test_mode_active(test_act), .sys_clock_out(sclk_o), .sdram_clock_out(sdram_clock_out_o),
      .sys_reset_n(srst_n), .jtag_logic_rst_n(jrst_n));

   // ----------------------------------------------------------------
   // Compare, report and bus tasks
   // ----------------------------------------------------------------
   task automatic chk1(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Entered just after a rising edge; leaves one idle cycle so no signal is driven twice in one step.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      if (n >= 50) chk1("pready", 1'b1, pready);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic experr);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk1("pslverr", experr, e);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m, input logic experr);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk32("prdata", exp & m, r & m);
      chk1("pslverr", experr, e);
   endtask

   task automatic clk_const(input logic exp);
      repeat (4) begin
         @(negedge pclk);
         chk1("sys_clock_out", exp, sclk_o);
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      repeat (8) @(posedge pclk);
      chk1("sys_reset_n", 1'b0, srst_n);
      chk32("pll factor", 32'(PLL_MF_NORM_X10), 32'(mult));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(negedge pclk);
      chk1("sys_reset_n", 1'b1, srst_n);
      @(posedge pclk);
      rdchk(CSRF_CTRL_OFS, CTRL_RESET_VAL, 32'hFFFF_FFFF, 1'b0);
   endtask

   task automatic t_straps();
      logic [MF_W-1:0] m;
      for (int i = 0; i < 4; i++) begin
         csrf_board_model_i.set_pins(i[0], i[1], 1'b1);
         m = i[1] ? PLL_MF_TEST_X10 : PLL_MF_NORM_X10;
         repeat (2) @(negedge pclk);
         chk1("sel_ext", i[0], sel_ext);
         chk1("test_mode", i[1], test_act);
         chk32("pll factor", 32'(m), 32'(mult));
         @(posedge pclk);
         rdchk(CSRF_STATUS_OFS, {17'h0, m, 6'h0, i[1], i[0]}, 32'h0000_7F03, 1'b0);
      end
   endtask

   task automatic t_clkout();
      logic prev;
      csrf_board_model_i.set_pins(1'b0, 1'b0, 1'b1);
      repeat (3) @(negedge pclk);
      prev = sclk_o;
      for (int k = 0; k < 4; k++) begin
         @(negedge pclk);
         chk1("sys_clock_out", ~prev, sclk_o);
         chk1("sdram_clock_out", sclk_o, sdram_clock_out_o);
         prev = sclk_o;
      end
      csrf_board_model_i.set_pins(1'b0, 1'b0, 1'b0);
      repeat (2) @(negedge pclk);
      clk_const(1'b0);
      csrf_board_model_i.set_pins(1'b0, 1'b0, 1'b1);
      wr(CSRF_CTRL_OFS, 32'h1234_5670, 1'b0);
      clk_const(1'b0);
      @(posedge pclk);
      rdchk(CSRF_CTRL_OFS, 32'h1234_5670, 32'hFFFF_FFFF, 1'b0);
      wr(CSRF_CTRL_OFS, CTRL_RESET_VAL, 1'b0);
   endtask

   task automatic t_rst_pulse(input int n, input logic acc);
      logic [31:0] c0, c1;
      logic e, seen_low, early_low;
      seen_low = 1'b0;
      early_low = 1'b0;
      @(posedge pclk);
      apb(1'b0, CSRF_RSTCNT_OFS, 32'h0000_0000, c0, e);
      fork
         csrf_board_model_i.hold_reset(n);
         for (int k = 1; k <= n + 6; k++) begin
            @(negedge pclk);
            if (srst_n !== 1'b1 && k <= RST_MIN_LOW_CYCLES) early_low = 1'b1;
            if (srst_n === 1'b0) seen_low = 1'b1;
         end
      join
      chk1("early reset", 1'b0, early_low);
      chk1("reset accepted", acc, seen_low);
      chk1("sys_reset_n", 1'b1, srst_n);
      @(posedge pclk);
      apb(1'b0, CSRF_RSTCNT_OFS, 32'h0000_0000, c1, e);
      chk32("reset count", (c0 + 32'(acc)) & 32'h0000_00FF, c1 & 32'h0000_00FF);
      if (acc) begin
         rdchk(CSRF_STATUS_OFS, 32'h0000_0008, 32'h0000_0008, 1'b0);
         wr(CSRF_STATUS_OFS, 32'h0000_0008, 1'b0);
         rdchk(CSRF_STATUS_OFS, 32'h0000_0000, 32'h0000_0008, 1'b0);
      end
   endtask

   task automatic t_jtag();
      csrf_board_model_i.set_jtag(1'b0);
      #10;
      chk1("jtag reset", 1'b0, jrst_n);
      chk1("sys_reset_n", 1'b1, srst_n);
      csrf_board_model_i.set_jtag(1'b1);
      repeat (2) @(negedge pclk);
      chk1("jtag reset", 1'b1, jrst_n);
   endtask

   task automatic t_err();
      logic [31:0] c, r;
      logic e;
      @(posedge pclk);
      apb(1'b0, CSRF_RSTCNT_OFS, 32'h0000_0000, c, e);
      apb(1'b1, CSRF_RSTCNT_OFS, 32'h0000_00FF, r, e);
      rdchk(CSRF_RSTCNT_OFS, c, 32'h0000_00FF, 1'b0);
      rdchk(12'h00C, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
      wr(12'h00C, 32'hFFFF_FFFF, 1'b1);
      rdchk(CSRF_CTRL_OFS, CTRL_RESET_VAL, 32'hFFFF_FFFF, 1'b0);
   endtask

   // Clock enable low must hold every flop, the clock image included.
   task automatic t_freeze();
      logic s0;
      @(posedge pclk);
      ce <= 1'b0;
      csrf_board_model_i.set_pins(1'b1, 1'b1, 1'b1);
      @(negedge pclk);
      s0 = sclk_o;
      repeat (3) begin
         @(negedge pclk);
         chk1("frozen sys_clock_out", s0, sclk_o);
         chk1("frozen sel_ext", 1'b0, sel_ext);
         chk1("frozen test_mode", 1'b0, test_act);
      end
      @(posedge pclk);
      ce <= 1'b1;
      repeat (2) @(negedge pclk);
      chk1("sel_ext", 1'b1, sel_ext);
      chk1("test_mode", 1'b1, test_act);
      chk32("pll factor", 32'(PLL_MF_TEST_X10), 32'(mult));
      chk1("sys_clock_out", ~s0, sclk_o);
   endtask

   initial begin
      t_reset();
      t_straps();
      t_clkout();
      t_rst_pulse(RST_MIN_LOW_CYCLES - 1, 1'b0);
      t_rst_pulse(RST_MIN_LOW_CYCLES, 1'b1);
      t_jtag();
      t_err();
      t_freeze();
      results();
   end

   // The tests need well under 2000 cycles; this cuts a hang short.
   initial begin
      #2_000_000;
      num_errors++;
      results();
   end
endmodule
